// ==== cssw_cfg.svh ====
/*
 * constants of the clock source switch: register offsets, field positions,
 * reset values and timing counts. assumes a 25 mhz register-side clock.
 */
`ifndef CSSW_CFG_SVH
`define CSSW_CFG_SVH

`define CSSW_ADDR_W           3
`define CSSW_OFF_MAIN_OSC     3'h0
`define CSSW_OFF_STAB_TIME    3'h1
`define CSSW_OFF_RUN_STOP     3'h2
`define CSSW_OFF_STAB_COUNT   3'h3
`define CSSW_OFF_SYS_CLK      3'h4
`define CSSW_OFF_SUB_SUPPLY   3'h5
`define CSSW_OFF_SUB_SELECT   3'h6

// main_osc_mode_ctrl fields
`define CSSW_B_HS_EXT         7
`define CSSW_B_HS_XTAL        6
`define CSSW_B_SUB_EXT        5
`define CSSW_B_SUB_XTAL       4
`define CSSW_MAIN_OSC_MASK    8'hF7
// osc_run_stop_ctrl fields
`define CSSW_B_HS_STOP        7
`define CSSW_B_SUB_STOP       6
`define CSSW_B_MID_EN         1
`define CSSW_B_FAST_STOP      0
`define CSSW_RUN_STOP_MASK    8'hC3
`define CSSW_RUN_STOP_RST     8'hC2
// system_clock_ctrl fields
`define CSSW_B_CPU_STAT       7
`define CSSW_B_CPU_SEL        6
`define CSSW_B_MAIN_STAT      5
`define CSSW_B_MAIN_SEL       4
`define CSSW_B_ONCHIP_STAT    1
`define CSSW_B_ONCHIP_SEL     0
// subclock_supply_mode fields, then subclock_source_select and osc_stab_time_select ones
`define CSSW_B_SUPPLY_LIMIT   7
`define CSSW_B_TIMER_LOWOSC   4
`define CSSW_SUB_SUPPLY_MASK  8'h90
`define CSSW_B_LOW_EN         0
`define CSSW_STAB_TIME_MASK   8'h07
`define CSSW_STAB_TIME_RST    8'h07

// switch handshake: cycles spent in the gap state; clk_gate stays low 6 cycles in all
`define CSSW_SWITCH_GAP       4
`define CSSW_CLK_MHZ          25
`define CSSW_FAST_STAB_US     65
`define CSSW_LOW_STAB_US      210
`define CSSW_FAST_STAB_CYC    ((`CSSW_FAST_STAB_US * `CSSW_CLK_MHZ))
`define CSSW_LOW_STAB_CYC     ((`CSSW_LOW_STAB_US * `CSSW_CLK_MHZ))

`endif

// ==== cssw_chk_assertions.sv ====
/*
 * port-level assertions of the clock source switch.
 * assumes one clock, synchronous active-high reset, bound to cssw_top.
 */
`timescale 1ns/1ps
`include "cssw_cfg.svh"

module cssw_chk (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire logic                    clk_en,
   input wire logic [`CSSW_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]              reg_wdata,
   input wire logic                    reg_write,
   input wire logic                    reg_read,
   input wire logic [7:0]              reg_rdata,
   input wire logic                    standby_req,
   input wire logic                    hs_crystal_run,
   input wire logic                    hs_external_input_sel,
   input wire logic                    sub_crystal_run,
   input wire logic                    sub_external_input_sel,
   input wire logic                    fast_osc_run,
   input wire logic                    mid_osc_run,
   input wire logic                    sub_clock_to_periph,
   input wire cssw_pkg::cssw_src_t     clk_src_sel,
   input wire logic                    clk_gate
);
   import cssw_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   // read data stands only in the cycle after a read strobe
   AST_RDATA_IDLE: assert property ($past(clk_en) && !$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   // oscillator enables follow the written bits, two edges on
   AST_FAST_RUN: assert property (clk_en && reg_write && reg_addr == `CSSW_OFF_RUN_STOP ##1 clk_en
      |=> fast_osc_run == !$past(reg_wdata[0], 2)) else $error("fast oscillator run wrong");
   AST_MID_RUN: assert property (clk_en && reg_write && reg_addr == `CSSW_OFF_RUN_STOP ##1 clk_en
      |=> mid_osc_run == $past(reg_wdata[1], 2)) else $error("middle oscillator run wrong");
   // crystal and external input of one source never both enabled
   AST_HS_EXCL: assert property (hs_crystal_run |-> !hs_external_input_sel)
      else $error("high-speed crystal and external input both on");
   AST_SUB_EXCL: assert property (sub_crystal_run |-> !sub_external_input_sel)
      else $error("subclock crystal and external input both on");
   // peripherals lose the subclock only in standby
   AST_PERIPH: assert property ($past(clk_en) && !sub_clock_to_periph |-> $past(standby_req))
      else $error("subclock withheld outside standby");
   // gate stays low for four cycles from its fall, then returns in bounded time
   AST_GATE_GAP: assert property ($fell(clk_gate) |-> !clk_gate [*4])
      else $error("clock gate reopened too early");
   AST_GATE_BOUND: assert property ($fell(clk_gate) |-> ##[1:20] clk_gate)
      else $error("clock gate stuck low");

   COV_HS: cover property ($changed(clk_src_sel) && clk_src_sel == CSSW_SRC_HS);
   COV_SUB: cover property ($changed(clk_src_sel) && clk_src_sel == CSSW_SRC_SUB);
   COV_READ: cover property (reg_read ##1 reg_rdata != 8'h00);
endmodule

bind cssw_top cssw_chk u_chk (.*);

// ==== cssw_pkg.sv ====
/*
 * types of the clock source switch. assumes cssw_cfg.svh holds the numbers.
 */
package cssw_pkg;
   // cpu/peripheral source seen by the glitch-free selector
   typedef enum logic [2:0] {
      CSSW_SRC_FAST = 3'h0,
      CSSW_SRC_MID  = 3'h1,
      CSSW_SRC_HS   = 3'h3,
      CSSW_SRC_SUB  = 3'h2,
      CSSW_SRC_LOW  = 3'h6
   } cssw_src_t;

   // switch sequencer, gray along idle-drain-gap-engage
   typedef enum logic [1:0] {
      CSSW_IDLE   = 2'h0,
      CSSW_DRAIN  = 2'h1,
      CSSW_GAP    = 2'h3,
      CSSW_ENGAGE = 2'h2
   } cssw_state_t;
endpackage

// ==== cssw_top.sv ====
/*
 * clock source switch: oscillator enables, x1 stabilization counter and a
 * glitch-free source selector steered by seven 8-bit registers.
 * assumes one 25 mhz clock and synchronous active-high reset.
 */
// Function
// - x1 select enables crystal; with external bit it selects external input
// - three stabilization-select bits pick x1 wait; 010 gives 2^10 cycles, 41 us
// - clearing x1 stop bit starts x1; external clock applied first
// - stabilization status reports elapsed x1 wait as thermometer bits
// - main-source select bit picks high-speed system clock or on-chip clock
// - main-source status reads 1 once main clock really switched to high-speed
// - clearing middle-speed enable stops middle oscillator; setting keeps it
// - timer lowosc bit makes low oscillator the interval timer count clock
// - supply-limit bit feeds only rtc and timer in standby from subclock
// - xt1 select enables subsystem crystal; with external bit selects input
// - clearing xt1 stop bit starts xt1; external clock applied first
// - cpu-source select bit picks subsystem clock or main system clock
// - cpu-source status reads 1 when cpu actually runs on subclock
// - clearing fast stop bit starts fast oscillator; software waits 65 us
// - clearing low-oscillator enable stops it; keep running for timer
// - on-chip speed select 0 picks fast oscillator, 1 middle oscillator
// - on-chip speed status shows which on-chip oscillator drives clock
// - setting low-oscillator enable starts it; 210 us before selection
`timescale 1ns/1ps
`include "cssw_cfg.svh"

module cssw_top #(
   parameter int STAB_W = 18 // x1 stabilization counter width, 2^18 max wait
) (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    clk_en,
   input  wire logic [`CSSW_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_write,
   input  wire logic                    reg_read,
   output logic      [7:0]              reg_rdata,
   input  wire logic                    standby_req,
   output logic                         hs_crystal_run,
   output logic                         hs_external_input_sel,
   output logic                         hs_gain_high,
   output logic                         sub_crystal_run,
   output logic                         sub_external_input_sel,
   output logic      [1:0]              sub_drive_sel,
   output logic                         fast_osc_run,
   output logic                         mid_osc_run,
   output logic                         low_osc_run,
   output logic                         interval_timer_lowosc_sel,
   output logic                         sub_clock_to_periph,
   output cssw_pkg::cssw_src_t          clk_src_sel,
   output logic                         clk_gate
);
   import cssw_pkg::*;

   initial begin
      if (STAB_W < 18 || STAB_W > 24) begin
         $error("cssw_top: STAB_W must be 18 to 24");
      end
   end

   logic [7:0]  main_osc_mode_ctrl;
   logic [7:0]  osc_stab_time_select;
   logic [7:0]  osc_run_stop_ctrl;
   logic [7:0]  subclock_supply_mode;
   logic [7:0]  subclock_source_select;
   logic        onchip_speed_select;
   logic        main_source_select;
   logic        cpu_source_select;
   logic        onchip_speed_status;
   logic        main_source_status;
   logic        cpu_source_status;
   logic [7:0]  osc_stab_count_status;
   // one spare bit so the longest wait, 2^18, is reachable before wrap
   logic [STAB_W:0] stab_count;
   logic        stab_hold;
   logic [7:0]  next_rdata;
   cssw_state_t sw_state;
   cssw_src_t   cur_src;
   cssw_src_t   want_src;
   logic [2:0]  gap_count;
   logic        hs_external_mode;

   // thermometer threshold: counter reached 2^bit
   function automatic logic reached(input logic [STAB_W:0] cnt, input int unsigned bitn);
      reached = |(cnt >> bitn);
   endfunction

   // wanted source from the select bits
   function automatic cssw_src_t pick_src(input logic cpu_sel, input logic main_sel,
                                          input logic speed_sel, input logic sub_xtal);
      if (cpu_sel) begin
         pick_src = sub_xtal ? CSSW_SRC_SUB : CSSW_SRC_LOW;
      end else if (main_sel) begin
         pick_src = CSSW_SRC_HS;
      end else begin
         pick_src = speed_sel ? CSSW_SRC_MID : CSSW_SRC_FAST;
      end
   endfunction

   // register writes; reserved bits masked off on the way in
   always_ff @(posedge clk) begin
      if (reset) begin
         main_osc_mode_ctrl     <= 8'h00;
         osc_stab_time_select   <= `CSSW_STAB_TIME_RST;
         osc_run_stop_ctrl      <= `CSSW_RUN_STOP_RST;
         subclock_supply_mode   <= 8'h00;
         subclock_source_select <= 8'h00;
         onchip_speed_select    <= 1'b1;
         main_source_select     <= 1'b0;
         cpu_source_select      <= 1'b0;
      end else if (clk_en && reg_write) begin
         case (reg_addr)
            `CSSW_OFF_MAIN_OSC: begin
               main_osc_mode_ctrl <= reg_wdata & `CSSW_MAIN_OSC_MASK;
            end
            `CSSW_OFF_STAB_TIME: begin
               osc_stab_time_select <= reg_wdata & `CSSW_STAB_TIME_MASK;
            end
            `CSSW_OFF_RUN_STOP: begin
               osc_run_stop_ctrl <= reg_wdata & `CSSW_RUN_STOP_MASK;
            end
            `CSSW_OFF_SYS_CLK: begin
               cpu_source_select   <= reg_wdata[`CSSW_B_CPU_SEL];
               // main select frozen while cpu runs on subclock, a harmless guard
               if (!cpu_source_status) begin
                  main_source_select <= reg_wdata[`CSSW_B_MAIN_SEL];
               end
               onchip_speed_select <= reg_wdata[`CSSW_B_ONCHIP_SEL];
            end
            `CSSW_OFF_SUB_SUPPLY: begin
               subclock_supply_mode <= reg_wdata & `CSSW_SUB_SUPPLY_MASK;
            end
            `CSSW_OFF_SUB_SELECT: begin
               subclock_source_select <= {7'h00, reg_wdata[`CSSW_B_LOW_EN]};
            end
            default: begin
            end
         endcase
      end
   end

   assign hs_external_mode = main_osc_mode_ctrl[`CSSW_B_HS_EXT];

   // x1 stabilization counter: restarts while x1 stopped; external input
   // is counted too, software simply does not wait for it
   always_ff @(posedge clk) begin
      if (reset) begin
         stab_count <= '0;
      end else if (clk_en) begin
         if (osc_run_stop_ctrl[`CSSW_B_HS_STOP] || !main_osc_mode_ctrl[`CSSW_B_HS_XTAL]) begin
            stab_count <= '0;
         end else if (!stab_hold) begin
            stab_count <= stab_count + (STAB_W+1)'(1);
         end
      end
   end

   // stop once the selected wait is reached: 2^(8..18) per select code
   always_comb begin
      case (osc_stab_time_select[2:0])
         3'h0: stab_hold = reached(stab_count, 8);
         3'h1: stab_hold = reached(stab_count, 9);
         3'h2: stab_hold = reached(stab_count, 10);
         3'h3: stab_hold = reached(stab_count, 11);
         3'h4: stab_hold = reached(stab_count, 13);
         3'h5: stab_hold = reached(stab_count, 15);
         3'h6: stab_hold = reached(stab_count, 17);
         default: stab_hold = reached(stab_count, 18);
      endcase
   end

   // thermometer status, msb is the shortest wait
   always_comb begin
      osc_stab_count_status[7] = reached(stab_count, 8);
      osc_stab_count_status[6] = reached(stab_count, 9);
      osc_stab_count_status[5] = reached(stab_count, 10);
      osc_stab_count_status[4] = reached(stab_count, 11);
      osc_stab_count_status[3] = reached(stab_count, 13);
      osc_stab_count_status[2] = reached(stab_count, 15);
      osc_stab_count_status[1] = reached(stab_count, 17);
      osc_stab_count_status[0] = reached(stab_count, 18);
   end

   // glitch-free switch: gate clock, wait, move cur_src, then move mux and ungate on one edge
   always_ff @(posedge clk) begin
      if (reset) begin
         sw_state  <= CSSW_IDLE;
         cur_src   <= CSSW_SRC_MID;
         want_src  <= CSSW_SRC_MID;
         gap_count <= 3'h0;
         clk_gate  <= 1'b1;
      end else if (clk_en) begin
         case (sw_state)
            CSSW_IDLE: begin
               want_src <= pick_src(cpu_source_select, main_source_select,
                                    onchip_speed_select,
                                    main_osc_mode_ctrl[`CSSW_B_SUB_XTAL]);
               if (want_src != cur_src) begin
                  clk_gate <= 1'b0;
                  sw_state <= CSSW_DRAIN;
               end
            end
            CSSW_DRAIN: begin
               gap_count <= 3'h0;
               sw_state  <= CSSW_GAP;
            end
            CSSW_GAP: begin
               gap_count <= gap_count + 3'h1;
               if (gap_count == 3'(`CSSW_SWITCH_GAP - 1)) begin
                  cur_src  <= want_src; // clk_src_sel follows on the edge clk_gate rises
                  sw_state <= CSSW_ENGAGE;
               end
            end
            CSSW_ENGAGE: begin
               clk_gate <= 1'b1;
               sw_state <= CSSW_IDLE;
            end
            default: begin
               sw_state <= CSSW_IDLE;
            end
         endcase
      end
   end

   // status bits follow the source actually engaged, not the request
   always_ff @(posedge clk) begin
      if (reset) begin
         onchip_speed_status <= 1'b1;
         main_source_status  <= 1'b0;
         cpu_source_status   <= 1'b0;
      end else if (clk_en && sw_state == CSSW_ENGAGE) begin
         cpu_source_status   <= (cur_src == CSSW_SRC_SUB) || (cur_src == CSSW_SRC_LOW);
         if (cur_src != CSSW_SRC_SUB && cur_src != CSSW_SRC_LOW) begin
            main_source_status  <= (cur_src == CSSW_SRC_HS);
            if (cur_src != CSSW_SRC_HS) begin
               onchip_speed_status <= (cur_src == CSSW_SRC_MID);
            end
         end
      end
   end

   // oscillator controls, timer clock, subclock supply and source select, all registered
   always_ff @(posedge clk) begin
      if (reset) begin
         hs_crystal_run            <= 1'b0;
         hs_external_input_sel     <= 1'b0;
         hs_gain_high              <= 1'b0;
         sub_crystal_run           <= 1'b0;
         sub_external_input_sel    <= 1'b0;
         sub_drive_sel             <= 2'h0;
         fast_osc_run              <= 1'b0;
         mid_osc_run               <= 1'b1;
         low_osc_run               <= 1'b0;
         interval_timer_lowosc_sel <= 1'b0;
         sub_clock_to_periph       <= 1'b1;
         clk_src_sel               <= CSSW_SRC_MID;
      end else if (clk_en) begin
         hs_crystal_run <= main_osc_mode_ctrl[`CSSW_B_HS_XTAL] && !hs_external_mode
                           && !osc_run_stop_ctrl[`CSSW_B_HS_STOP];
         hs_external_input_sel <= main_osc_mode_ctrl[`CSSW_B_HS_XTAL] && hs_external_mode
                                  && !osc_run_stop_ctrl[`CSSW_B_HS_STOP];
         hs_gain_high <= main_osc_mode_ctrl[0];
         sub_crystal_run <= main_osc_mode_ctrl[`CSSW_B_SUB_XTAL]
                            && !main_osc_mode_ctrl[`CSSW_B_SUB_EXT]
                            && !osc_run_stop_ctrl[`CSSW_B_SUB_STOP];
         sub_external_input_sel <= main_osc_mode_ctrl[`CSSW_B_SUB_XTAL]
                                   && main_osc_mode_ctrl[`CSSW_B_SUB_EXT]
                                   && !osc_run_stop_ctrl[`CSSW_B_SUB_STOP];
         sub_drive_sel <= main_osc_mode_ctrl[2:1];
         fast_osc_run <= !osc_run_stop_ctrl[`CSSW_B_FAST_STOP];
         mid_osc_run  <= osc_run_stop_ctrl[`CSSW_B_MID_EN];
         low_osc_run  <= subclock_source_select[`CSSW_B_LOW_EN];
         interval_timer_lowosc_sel <= subclock_supply_mode[`CSSW_B_TIMER_LOWOSC];
         // in standby with the limit set, only rtc and timer keep the subclock
         sub_clock_to_periph <= !(subclock_supply_mode[`CSSW_B_SUPPLY_LIMIT]
                                  && standby_req);
         clk_src_sel <= cur_src;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      case (reg_addr)
         `CSSW_OFF_MAIN_OSC:   next_rdata = main_osc_mode_ctrl;
         `CSSW_OFF_STAB_TIME:  next_rdata = osc_stab_time_select;
         `CSSW_OFF_RUN_STOP:   next_rdata = osc_run_stop_ctrl;
         `CSSW_OFF_STAB_COUNT: next_rdata = osc_stab_count_status;
         `CSSW_OFF_SYS_CLK:    next_rdata = {cpu_source_status, cpu_source_select,
                                             main_source_status, main_source_select,
                                             2'h0, onchip_speed_status,
                                             onchip_speed_select};
         `CSSW_OFF_SUB_SUPPLY: next_rdata = subclock_supply_mode;
         `CSSW_OFF_SUB_SELECT: next_rdata = subclock_source_select;
         default:              next_rdata = 8'h00;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= reg_read ? next_rdata : 8'h00;
      end
   end
endmodule

// ==== tb.sv ====
/*
 * self-checking bench of the clock source switch: register accesses,
 * source switches and output checks. assumes a 25 mhz clock.
 */
`timescale 1ns/1ps
`include "cssw_cfg.svh"

module tb;
   import cssw_pkg::*;
   logic                    clk, reset, clk_en, reg_write, reg_read, standby_req;
   logic [`CSSW_ADDR_W-1:0] reg_addr, a;
   logic [7:0]              reg_wdata, reg_rdata, rd_val, d;
   logic                    hs_run, hs_ext, gain, sub_run, sub_ext, fast_run, mid_run;
   logic                    low_run, tmr_low, sub_per, gate;
   logic [1:0]              drive;
   cssw_src_t               src;
   int                      err_count, checks_done, seed;

   cssw_top #(.STAB_W(18)) DUT (.clk(clk), .reset(reset), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .standby_req(standby_req),
      .hs_crystal_run(hs_run), .hs_external_input_sel(hs_ext), .hs_gain_high(gain),
      .sub_crystal_run(sub_run), .sub_external_input_sel(sub_ext), .sub_drive_sel(drive),
      .fast_osc_run(fast_run), .mid_osc_run(mid_run), .low_osc_run(low_run),
      .interval_timer_lowosc_sel(tmr_low), .sub_clock_to_periph(sub_per),
      .clk_src_sel(src), .clk_gate(gate));

   // writable bits of each register except system_clock_ctrl, reserved ones stay zero
   function automatic logic [7:0] rw_mask(input logic [2:0] x);
      case (x)
         3'h0: return 8'hF7;
         3'h1: return 8'h07;
         3'h2: return 8'hC3;
         3'h5: return 8'h90;
         3'h6: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] rst_val(input logic [2:0] x);
      case (x)
         3'h1: return 8'h07;
         3'h2: return 8'hC2;
         3'h4: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] x, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= x;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // read data is taken in the cycle right after the strobe
   task automatic rd(input logic [2:0] x);
      @(posedge clk);
      reg_addr <= x;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   task automatic rdchk(input logic [2:0] x, input logic [7:0] exp);
      rd(x);
      check("register", rd_val, exp);
   endtask

   // bounded status poll; running out is a failure
   task automatic poll(input logic [2:0] x, input logic [7:0] m, input logic [7:0] v);
      int i;
      for (i = 0; i < 800; i++) begin
         rd(x);
         if ((rd_val & m) === v)
            break;
      end
      if (i == 800) begin
         err_count++;
         $display("CHECK FAILED poll expected %h seen %h", v, rd_val & m);
         stop_test();
      end
   endtask

   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      standby_req = 1'b0;
      err_count = 0;
      checks_done = 0;
      seed = $urandom(32'h2F64);
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      // reset values, unmapped offset included
      for (int n = 0; n < 8; n++) begin
         rd(3'(n));
         check("reset value", rd_val, rst_val(3'(n)));
      end
      check("reset source", {5'h0, src}, {5'h0, CSSW_SRC_MID});
      check("reset mid", {7'h0, mid_run}, 8'h01);
      // random writes: reserved bits drop, outputs follow
      for (int n = 0; n < 24; n++) begin
         a = 3'($urandom_range(6));
         if (a == 3'h3 || a == 3'h4)
            a = 3'h6;
         d = 8'($urandom);
         wr(a, d);
         rdchk(a, d & rw_mask(a));
         case (a)
            3'h0: check("gain", {5'h0, drive, gain}, {5'h0, d[2:0]});
            3'h2: check("mid run", {7'h0, mid_run}, {7'h0, d[1]});
            3'h5: check("timer clock", {7'h0, tmr_low}, {7'h0, d[4]});
            3'h6: check("low run", {7'h0, low_run}, {7'h0, d[0]});
            default: ;
         endcase
      end
      // second reset in mid-run restores defaults
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdchk(3'h2, 8'hC2);
      // middle-speed to crystal main clock with a 2^10 wait
      wr(3'h0, 8'h40);
      wr(3'h1, 8'h02);
      wr(3'h2, 8'h03);
      settle();
      check("x1 run", {6'h0, hs_run, hs_ext}, 8'h02);
      poll(3'h3, 8'hFF, 8'hE0);
      wr(3'h3, 8'hFF);
      rdchk(3'h3, 8'hE0);
      wr(3'h4, 8'h11);
      poll(3'h4, 8'h20, 8'h20);
      rdchk(3'h4, 8'h33);
      check("source hs", {5'h0, src}, {5'h0, CSSW_SRC_HS});
      wr(3'h2, 8'h01);
      settle();
      check("mid stop", {7'h0, mid_run}, 8'h00);
      // on to the subsystem crystal
      wr(3'h5, 8'h90);
      wr(3'h0, 8'h50);
      settle();
      check("xt1 run", {6'h0, sub_run, tmr_low}, 8'h03);
      // software times the xt1 start-up itself, no counter helps here
      repeat (100) @(posedge clk);
      wr(3'h4, 8'h51);
      poll(3'h4, 8'h80, 8'h80);
      check("source sub", {5'h0, src}, {5'h0, CSSW_SRC_SUB});
      wr(3'h4, 8'h41);
      rdchk(3'h4, 8'hF3);
      @(posedge clk);
      standby_req <= 1'b1;
      settle();
      check("standby supply", {7'h0, sub_per}, 8'h00);
      @(posedge clk);
      standby_req <= 1'b0;
      settle();
      check("awake supply", {7'h0, sub_per}, 8'h01);
      wr(3'h4, 8'h11);
      poll(3'h4, 8'h80, 8'h00);
      check("back to hs", {5'h0, src}, {5'h0, CSSW_SRC_HS});
      // fast on-chip oscillator, then the low-speed one
      wr(3'h2, 8'h00);
      repeat (`CSSW_FAST_STAB_CYC) @(posedge clk);
      wr(3'h4, 8'h00);
      poll(3'h4, 8'h22, 8'h00);
      rdchk(3'h4, 8'h00);
      check("source fast", {5'h0, src}, {5'h0, CSSW_SRC_FAST});
      wr(3'h6, 8'h01);
      repeat (`CSSW_LOW_STAB_CYC) @(posedge clk);
      wr(3'h0, 8'h00);
      wr(3'h4, 8'h40);
      poll(3'h4, 8'h80, 8'h80);
      check("source low", {5'h0, src}, {5'h0, CSSW_SRC_LOW});
      wr(3'h4, 8'h00);
      poll(3'h4, 8'h80, 8'h00);
      wr(3'h6, 8'h00);
      settle();
      check("low stop", {7'h0, low_run}, 8'h00);
      // frozen block ignores a write
      @(posedge clk);
      clk_en <= 1'b0;
      wr(3'h6, 8'h01);
      clk_en <= 1'b1;
      rdchk(3'h6, 8'h00);
      // external inputs for both sources, no stabilization wait taken
      wr(3'h0, 8'hF0);
      settle();
      check("external", {4'h0, hs_run, hs_ext, sub_run, sub_ext}, 8'h05);
      stop_test();
   end
endmodule
